// File: temp_ctrl_chk.sv
// Port checker for the temperature measurement control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module temp_ctrl_chk
	import temp_ctrl_pkg::*;
(
	input wire logic        REF_CLK_I,
	input wire logic        RSTN_I,
	input wire logic        AWVALID_I,
	input wire logic        AWREADY_O,
	input wire logic        WVALID_I,
	input wire logic        WREADY_O,
	input wire logic [1:0]  BRESP_O,
	input wire logic        BVALID_O,
	input wire logic        BREADY_I,
	input wire logic        ARVALID_I,
	input wire logic        ARREADY_O,
	input wire logic [31:0] RDATA_O,
	input wire logic        RVALID_O,
	input wire logic        RREADY_I,
	input wire logic [1:0]  MODE_I,
	input wire logic        MEAS_DONE_I,
	input wire logic        MEAS_START_O,
	input wire logic        SENSOR_SUPPLY_MAIN_O,
	input wire logic [5:0]  TEST_MUX_SEL_O
);
	logic meas;

	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RSTN_I);

	////////////////////////////////////////////////////////////////////////////////
	// Measurement in flight
	always_ff @(posedge REF_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			meas <= 1'h0;
		else if (MEAS_START_O)
			meas <= 1'h1;
		else if (MEAS_DONE_I)
			meas <= 1'h0;
	end

	////////////////////////////////////////////////////////////////////////////////
	property p_start_pulse; MEAS_START_O |=> !MEAS_START_O; endproperty
	a_start_pulse: assert property (p_start_pulse)
		else $error("start pulse too long");
	property p_start_idle; meas |-> !MEAS_START_O; endproperty
	a_start_idle: assert property (p_start_idle)
		else $error("start while measuring");
	property p_supply_sleep; MODE_I == MODE_SLEEP |-> !SENSOR_SUPPLY_MAIN_O; endproperty
	a_supply_sleep: assert property (p_supply_sleep)
		else $error("main supply in sleep");
	property p_mux_write; $changed(TEST_MUX_SEL_O) |-> BVALID_O; endproperty
	a_mux_write: assert property (p_mux_write)
		else $error("mux select changed without write");
	property p_b_hold; BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O); endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped");
	property p_r_hold; RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O); endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped");
	property p_ar_block; RVALID_O |-> !ARREADY_O; endproperty
	a_ar_block: assert property (p_ar_block)
		else $error("read address taken while answering");
	property p_rd_answer; ARVALID_I && ARREADY_O |=> RVALID_O; endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read answer late");
	property p_wr_answer; AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2 BVALID_O;
	endproperty
	a_wr_answer: assert property (p_wr_answer)
		else $error("write answer late");

	c_start: cover property (MEAS_START_O);
	c_sleep_start: cover property (MODE_I == MODE_SLEEP && MEAS_START_O);
	c_slverr: cover property (BVALID_O && BRESP_O == RESP_SLVERR);
endmodule : temp_ctrl_chk

bind temp_measure_ctrl temp_ctrl_chk temp_ctrl_chk_i (.REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I),
	.AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
	.BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARVALID_I(ARVALID_I),
	.ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
	.MODE_I(MODE_I), .MEAS_DONE_I(MEAS_DONE_I), .MEAS_START_O(MEAS_START_O),
	.SENSOR_SUPPLY_MAIN_O(SENSOR_SUPPLY_MAIN_O), .TEST_MUX_SEL_O(TEST_MUX_SEL_O));
`default_nettype wire

// File: temp_ctrl_pkg.sv
// Package for the temperature measurement control block.
// Assumes a 32-bit AXI4-Lite register bus and a 125 MHz system clock.
package temp_ctrl_pkg;

	// Register offsets. Printed offsets are not word aligned, so each is an index.
	localparam logic [15:0] IDX_TEST_MUX        = 16'h2502;
	localparam logic [15:0] IDX_TEST_MUX_TWO    = 16'h2503;
	localparam logic [15:0] IDX_REMOTE_MUX      = 16'h270a;
	localparam logic [15:0] IDX_TEMP_CTRL       = 16'h28a0;
	localparam logic [15:0] IDX_ONESHOT         = 16'h28b4;
	localparam logic [15:0] IDX_RESULT_LO       = 16'h2881;
	localparam logic [15:0] IDX_RESULT_HI       = 16'h2882;
	localparam logic [15:0] IDX_MODE           = 16'h2f00;

	// Field positions in the temperature control byte
	localparam int PERIOD_LSB    = 0;
	localparam int BUSY_BIT      = 3;
	localparam int BATMEAS_BIT   = 4;
	localparam int SUPPLY_BIT    = 6;
	localparam int BATSEL_BIT    = 7;
	// Field position in the one-shot byte
	localparam int ONESHOT_BIT   = 6;

	// Reset values
	localparam logic [2:0] PERIOD_RST   = 3'h0;
	localparam logic [2:0] REMOTE_RST   = 3'h0;
	localparam logic [5:0] TEST_MUX_SELECT_RST     = 6'h00;
	localparam logic [4:0] TEST_MUX_TWO_SELECT_RST    = 5'h00;

	// Period field codes
	localparam logic [2:0] PERIOD_OFF   = 3'h0;
	localparam logic [2:0] PERIOD_CONT  = 3'h7;
	localparam int         PERIOD_BASE  = 3;

	// Timing
	localparam int CLK_MHZ         = 125;
	localparam int COMMIT_MS       = 6;
	localparam int COMMIT_CYCLES   = COMMIT_MS * 1000 * CLK_MHZ;

	// Operating modes
	typedef enum logic [1:0] {
		MODE_MISSION  = 2'h0,
		MODE_BROWNOUT = 2'h1,
		MODE_SLEEP    = 2'h2
	} op_mode_t;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Byte address of a register index
	function automatic logic [17:0] byte_addr(input logic [15:0] idx);
		byte_addr = {idx, 2'h0};
	endfunction : byte_addr

endpackage : temp_ctrl_pkg

// File: temp_measure_ctrl.sv
// Temperature measurement control with AXI4-Lite register access.
// Assumes a sensor front end with a start/done handshake and a 1 s tick.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Period field: off, 2^(3+n) s, continuous
// - Automatic measurements in every mode
// - One-shot start when period is zero
// - One-shot start ignored in sleep
// - Hardware clears start bit when done
// - Start bit reads sensor busy in auto
// - Supply select; sleep forces clock battery
// - Two test mux selects, of 64 and of 32
// - Remote mux select, resets to zero
// - Result register updated per measurement
// - Battery measure enable and select
// - Control byte commit busy locks writes
module temp_measure_ctrl
	import temp_ctrl_pkg::*;
#(
	parameter int COMMIT_CNT = COMMIT_CYCLES,
	parameter int RESULT_W   = 16
)
(
	input  wire logic                REF_CLK_I,
	input  wire logic                RSTN_I,
	input  wire logic [17:0]         AWADDR_I,
	input  wire logic                AWVALID_I,
	output logic                     AWREADY_O,
	input  wire logic [31:0]         WDATA_I,
	input  wire logic [3:0]          WSTRB_I,
	input  wire logic                WVALID_I,
	output logic                     WREADY_O,
	output logic [1:0]               BRESP_O,
	output logic                     BVALID_O,
	input  wire logic                BREADY_I,
	input  wire logic [17:0]         ARADDR_I,
	input  wire logic                ARVALID_I,
	output logic                     ARREADY_O,
	output logic [31:0]              RDATA_O,
	output logic [1:0]               RRESP_O,
	output logic                     RVALID_O,
	input  wire logic                RREADY_I,
	input  wire logic [1:0]          MODE_I,
	input  wire logic                SEC_TICK_I,
	input  wire logic                MEAS_DONE_I,
	input  wire logic [RESULT_W-1:0] MEAS_RESULT_I,
	output logic                     MEAS_START_O,
	output logic                     MEAS_BAT_EN_O,
	output logic                     MEAS_BAT_SEL_O,
	output logic                     SENSOR_SUPPLY_MAIN_O,
	output logic [5:0]               TEST_MUX_SEL_O,
	output logic [4:0]               TEST_MUX_TWO_SEL_O,
	output logic [2:0]               REMOTE_MUX_SEL_O
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_MEAS = 2'b01
	} meas_state_t;

	logic                aw_held;
	logic                w_held;
	logic [17:0]         aw_addr;
	logic [31:0]         w_data;
	logic [3:0]          w_strb;
	logic                bvalid;
	logic [1:0]          bresp;
	logic                rvalid;
	logic [31:0]         rdata;
	logic [1:0]          rresp;
	logic [5:0]          test_mux_select;
	logic [4:0]          test_mux_two_select;
	logic [2:0]          remote_sensor_mux_select;
	logic [2:0]          period;
	logic                battery_measure_enable;
	logic                sensor_supply_select;
	logic                battery_select;
	logic                oneshot;
	logic [31:0]         commit_cnt;
	logic [RESULT_W-1:0] temperature_result;
	meas_state_t         state;
	logic                start;

	logic                next_aw_held;
	logic                next_w_held;
	logic [17:0]         next_aw_addr;
	logic [31:0]         next_w_data;
	logic [3:0]          next_w_strb;
	logic                next_bvalid;
	logic [1:0]          next_bresp;
	logic                next_rvalid;
	logic [31:0]         next_rdata;
	logic [1:0]          next_rresp;
	logic [5:0]          next_test_mux_select;
	logic [4:0]          next_test_mux_two_select;
	logic [2:0]          next_remote_sensor_mux_select;
	logic [2:0]          next_period;
	logic                next_battery_measure_enable;
	logic                next_sensor_supply_select;
	logic                next_battery_select;
	logic                next_oneshot;
	logic [31:0]         next_commit_cnt;
	logic [RESULT_W-1:0] next_temperature_result;
	meas_state_t         next_state;
	logic                next_start;

	logic                sleep_mode;
	logic                sched_req;
	logic                do_write;
	logic                oneshot_req;
	logic                commit_busy;

	assign sleep_mode  = (MODE_I == MODE_SLEEP);
	assign commit_busy = (commit_cnt != 32'h0);
	assign do_write    = aw_held && w_held && !bvalid;

	////////////////////////////////////////////////////////////////////////////////
	// Scheduler

	temp_period_sched temp_period_sched_i (
		.clk_i      (REF_CLK_I),
		.rst_n_i    (RSTN_I),
		.period_i   (period),
		.sec_tick_i (SEC_TICK_I),
		.busy_i     (state != S_IDLE),
		.req_o      (sched_req)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Bus and registers

	assign AWREADY_O = !aw_held;
	assign WREADY_O  = !w_held;
	assign ARREADY_O = !rvalid;
	assign BVALID_O  = bvalid;
	assign BRESP_O   = bresp;
	assign RVALID_O  = rvalid;
	assign RDATA_O   = rdata;
	assign RRESP_O   = rresp;

	always_comb
	begin
		next_aw_held                  = aw_held;
		next_w_held                   = w_held;
		next_aw_addr                  = aw_addr;
		next_w_data                   = w_data;
		next_w_strb                   = w_strb;
		next_bvalid                   = bvalid;
		next_bresp                    = bresp;
		next_rvalid                   = rvalid;
		next_rdata                    = rdata;
		next_rresp                    = rresp;
		next_test_mux_select          = test_mux_select;
		next_test_mux_two_select      = test_mux_two_select;
		next_remote_sensor_mux_select = remote_sensor_mux_select;
		next_period                   = period;
		next_battery_measure_enable   = battery_measure_enable;
		next_sensor_supply_select     = sensor_supply_select;
		next_battery_select           = battery_select;
		next_commit_cnt               = commit_busy ? commit_cnt - 32'h1 : commit_cnt;
		oneshot_req                   = 1'b0;

		if (AWVALID_I && !aw_held)
		begin
			next_aw_held = 1'b1;
			next_aw_addr = AWADDR_I;
		end
		if (WVALID_I && !w_held)
		begin
			next_w_held = 1'b1;
			next_w_data = WDATA_I;
			next_w_strb = WSTRB_I;
		end
		if (bvalid && BREADY_I)
			next_bvalid = 1'b0;

		if (do_write)
		begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = RESP_OKAY;
			if (!w_strb[0])
			begin
			end
			else if (aw_addr[17:2] == IDX_TEST_MUX)
			begin
				next_test_mux_select = w_data[5:0];
			end
			else if (aw_addr[17:2] == IDX_TEST_MUX_TWO)
			begin
				next_test_mux_two_select = w_data[4:0];
			end
			else if (aw_addr[17:2] == IDX_REMOTE_MUX)
			begin
				next_remote_sensor_mux_select = w_data[2:0];
			end
			else if (aw_addr[17:2] == IDX_TEMP_CTRL)
			begin
				if (!commit_busy)
				begin
					next_period                 = w_data[PERIOD_LSB +: 3];
					next_battery_measure_enable = w_data[BATMEAS_BIT];
					next_sensor_supply_select   = w_data[SUPPLY_BIT];
					next_battery_select         = w_data[BATSEL_BIT];
					next_commit_cnt             = 32'(COMMIT_CNT);
				end
			end
			else if (aw_addr[17:2] == IDX_ONESHOT)
			begin
				oneshot_req = w_data[ONESHOT_BIT];
			end
			else if (aw_addr[17:2] != IDX_RESULT_LO && aw_addr[17:2] != IDX_RESULT_HI
				&& aw_addr[17:2] != IDX_MODE)
			begin
				next_bresp = RESP_SLVERR;
			end
		end

		if (rvalid && RREADY_I)
			next_rvalid = 1'b0;
		if (ARVALID_I && !rvalid)
		begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			next_rdata  = 32'h0;
			case (ARADDR_I[17:2])
				IDX_TEST_MUX:     next_rdata = {26'h0, test_mux_select};
				IDX_TEST_MUX_TWO: next_rdata = {27'h0, test_mux_two_select};
				IDX_REMOTE_MUX:   next_rdata = {29'h0, remote_sensor_mux_select};
				IDX_TEMP_CTRL:    next_rdata = {24'h0, battery_select, sensor_supply_select,
					1'b0, battery_measure_enable, commit_busy, period};
				IDX_ONESHOT:      next_rdata = 32'((state != S_IDLE) || oneshot) << ONESHOT_BIT;
				IDX_RESULT_LO:    next_rdata = {24'h0, temperature_result[7:0]};
				IDX_RESULT_HI:    next_rdata = {24'h0, temperature_result[RESULT_W-1:8]};
				IDX_MODE:         next_rdata = {30'h0, MODE_I};
				default:          next_rresp = RESP_SLVERR;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Measurement sequencer

	always_comb
	begin
		next_state              = state;
		next_start              = 1'b0;
		next_oneshot            = oneshot;
		next_temperature_result = temperature_result;
		case (state)
			S_IDLE:
			begin
				if (oneshot_req && period == PERIOD_OFF && !sleep_mode)
				begin
					next_oneshot = 1'b1;
					next_state   = S_MEAS;
					next_start   = 1'b1;
				end
				else if (sched_req)
				begin
					next_state = S_MEAS;
					next_start = 1'b1;
				end
			end
			S_MEAS:
			begin
				if (MEAS_DONE_I)
				begin
					next_temperature_result = MEAS_RESULT_I;
					next_oneshot            = 1'b0;
					next_state              = S_IDLE;
				end
			end
			default:
				next_state = S_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge REF_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			aw_held                  <= 1'b0;
			w_held                   <= 1'b0;
			aw_addr                  <= 18'h0;
			w_data                   <= 32'h0;
			w_strb                   <= 4'h0;
			bvalid                   <= 1'b0;
			bresp                    <= RESP_OKAY;
			rvalid                   <= 1'b0;
			rdata                    <= 32'h0;
			rresp                    <= RESP_OKAY;
			test_mux_select          <= TEST_MUX_SELECT_RST;
			test_mux_two_select      <= TEST_MUX_TWO_SELECT_RST;
			remote_sensor_mux_select <= REMOTE_RST;
			period                   <= PERIOD_RST;
			battery_measure_enable   <= 1'b0;
			sensor_supply_select     <= 1'b0;
			battery_select           <= 1'b0;
			oneshot                  <= 1'b0;
			commit_cnt               <= 32'h0;
			temperature_result       <= '0;
			state                    <= S_IDLE;
			start                    <= 1'b0;
		end
		else
		begin
			aw_held                  <= next_aw_held;
			w_held                   <= next_w_held;
			aw_addr                  <= next_aw_addr;
			w_data                   <= next_w_data;
			w_strb                   <= next_w_strb;
			bvalid                   <= next_bvalid;
			bresp                    <= next_bresp;
			rvalid                   <= next_rvalid;
			rdata                    <= next_rdata;
			rresp                    <= next_rresp;
			test_mux_select          <= next_test_mux_select;
			test_mux_two_select      <= next_test_mux_two_select;
			remote_sensor_mux_select <= next_remote_sensor_mux_select;
			period                   <= next_period;
			battery_measure_enable   <= next_battery_measure_enable;
			sensor_supply_select     <= next_sensor_supply_select;
			battery_select           <= next_battery_select;
			oneshot                  <= next_oneshot;
			commit_cnt               <= next_commit_cnt;
			temperature_result       <= next_temperature_result;
			state                    <= next_state;
			start                    <= next_start;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign MEAS_START_O         = start;
	assign MEAS_BAT_EN_O        = battery_measure_enable;
	assign MEAS_BAT_SEL_O       = battery_select;
	assign SENSOR_SUPPLY_MAIN_O = sensor_supply_select && !sleep_mode;
	assign TEST_MUX_SEL_O       = test_mux_select;
	assign TEST_MUX_TWO_SEL_O   = test_mux_two_select;
	assign REMOTE_MUX_SEL_O     = remote_sensor_mux_select;

endmodule : temp_measure_ctrl
`default_nettype wire

// File: temp_period_sched.sv
// Periodic measurement scheduler.
// Assumes a one-cycle second tick synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none
module temp_period_sched
	import temp_ctrl_pkg::*;
#(
	parameter int SEC_W = 10
)
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [2:0] period_i,
	input  wire logic       sec_tick_i,
	input  wire logic       busy_i,
	output logic            req_o
);

	logic [SEC_W-1:0] sec_cnt;
	logic [SEC_W-1:0] next_sec_cnt;
	logic [SEC_W-1:0] limit;

	// Period of two to the three plus field
	always_comb
	begin
		limit = SEC_W'((1 << (PERIOD_BASE + 32'(period_i))) - 1);
	end

	always_comb
	begin
		next_sec_cnt = sec_cnt;
		req_o        = 1'b0;
		if (period_i == PERIOD_OFF)
		begin
			next_sec_cnt = '0;
		end
		else if (period_i == PERIOD_CONT)
		begin
			req_o = !busy_i;
		end
		else if (sec_tick_i)
		begin
			if (sec_cnt >= limit)
			begin
				next_sec_cnt = '0;
				req_o        = !busy_i;
			end
			else
			begin
				next_sec_cnt = sec_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			sec_cnt <= '0;
		else
			sec_cnt <= next_sec_cnt;
	end

endmodule : temp_period_sched
`default_nettype wire

// File: temp_sensor_model.sv
// Behavioural temperature sensor front end.
// Assumes a one-cycle start pulse; answers lat_i+1 cycles after it samples the start.
`timescale 1ns/10ps
`default_nettype none
module temp_sensor_model
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       start_i,
	input  wire logic [7:0] lat_i,
	output logic            done_o,
	output logic [15:0]     result_o
);
	logic [7:0]  cnt;
	logic        busy;
	logic [15:0] res;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			busy <= 1'h0;
			cnt <= 8'h0;
			res <= 16'h5a3c;
			done_o <= 1'h0;
		end
		else
		begin
			done_o <= busy && cnt == 8'h0;
			if (done_o)
				res <= res + 16'h1;
			if (start_i && !busy)
			begin
				busy <= 1'h1;
				cnt <= lat_i;
			end
			else if (busy && cnt == 8'h0)
				busy <= 1'h0;
			else if (busy)
				cnt <= cnt - 8'h1;
		end
	end

	assign result_o = done_o ? res : ~res;
endmodule : temp_sensor_model
`default_nettype wire

// File: temperature_measure_control_tb.sv
// Testbench for the temperature measurement control block.
// Assumes the sensor model on the far side and AXI4-Lite register access.
`timescale 1ns/10ps
`default_nettype none
module temperature_measure_control_tb
	import temp_ctrl_pkg::*;
;
	typedef struct packed {
		logic [15:0] idx;
		logic [7:0]  wd;
		logic [31:0] rd;
		logic [1:0]  rsp;
	} row_t;
	logic        REF_CLK_I = 1'h0, RSTN_I = 1'h0, SEC_TICK_I = 1'h0, tick_en = 1'h0;
	logic        AWVALID_I = 1'h0, WVALID_I = 1'h0, BREADY_I = 1'h0;
	logic        ARVALID_I = 1'h0, RREADY_I = 1'h0;
	logic [17:0] AWADDR_I = 18'h0, ARADDR_I = 18'h0;
	logic [31:0] WDATA_I = 32'h0, RDATA_O, q;
	logic [3:0]  WSTRB_I = 4'h0;
	logic [3:0]  strb = 4'hf;
	logic [1:0]  MODE_I = 2'h0, BRESP_O, RRESP_O, r;
	logic [7:0]  lat = 8'h1e;
	logic        AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
	logic        MEAS_DONE_I, MEAS_START_O, MEAS_BAT_EN_O, MEAS_BAT_SEL_O, SENSOR_SUPPLY_MAIN_O;
	logic [15:0] MEAS_RESULT_I;
	logic [5:0]  TEST_MUX_SEL_O;
	logic [4:0]  TEST_MUX_TWO_SEL_O;
	logic [2:0]  REMOTE_MUX_SEL_O;
	int          error_cnt = 0, compares = 0, st_cnt = 0, cyc = 0, last = 0, gap = 0, s0, k;
	row_t        rows [6] = '{
		'{IDX_TEST_MUX, 8'hff, 32'h3f, RESP_OKAY},
		'{IDX_TEST_MUX_TWO, 8'hff, 32'h1f, RESP_OKAY},
		'{IDX_REMOTE_MUX, 8'hff, 32'h07, RESP_OKAY},
		'{IDX_REMOTE_MUX, 8'h05, 32'h05, RESP_OKAY},
		'{IDX_TEST_MUX, 8'h2a, 32'h2a, RESP_OKAY},
		'{16'h1234, 8'h5a, 32'h00, RESP_SLVERR}};

	always #4 REF_CLK_I = ~REF_CLK_I;

	temp_measure_ctrl #(.COMMIT_CNT(20)) temp_measure_ctrl_i (.REF_CLK_I(REF_CLK_I),
		.RSTN_I(RSTN_I), .AWADDR_I(AWADDR_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
		.WDATA_I(WDATA_I), .WSTRB_I(WSTRB_I), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
		.BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARADDR_I(ARADDR_I),
		.ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O),
		.RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .MODE_I(MODE_I), .SEC_TICK_I(SEC_TICK_I),
		.MEAS_DONE_I(MEAS_DONE_I), .MEAS_RESULT_I(MEAS_RESULT_I), .MEAS_START_O(MEAS_START_O),
		.MEAS_BAT_EN_O(MEAS_BAT_EN_O), .MEAS_BAT_SEL_O(MEAS_BAT_SEL_O),
		.SENSOR_SUPPLY_MAIN_O(SENSOR_SUPPLY_MAIN_O), .TEST_MUX_SEL_O(TEST_MUX_SEL_O),
		.TEST_MUX_TWO_SEL_O(TEST_MUX_TWO_SEL_O), .REMOTE_MUX_SEL_O(REMOTE_MUX_SEL_O));
	temp_sensor_model temp_sensor_model_i (.clk_i(REF_CLK_I), .rst_n_i(RSTN_I),
		.start_i(MEAS_START_O), .lat_i(lat), .done_o(MEAS_DONE_I), .result_o(MEAS_RESULT_I));

	////////////////////////////////////////////////////////////////////////////////
	// Second tick and start monitor
	always @(posedge REF_CLK_I)
	begin
		cyc <= cyc + 1;
		SEC_TICK_I <= tick_en && (cyc % 4 == 0);
		if (MEAS_START_O)
		begin
			st_cnt <= st_cnt + 1;
			gap <= cyc - last;
			last <= cyc;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		if (error_cnt == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish

	task automatic give_up(input logic hit);
		if (hit)
		begin
			error_cnt++;
			tally_and_finish;
		end
	endtask : give_up

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
		logic pa, pw, pr, ta, tw, tr, tb, rr, fin;
		@(posedge REF_CLK_I);
		if (w)
		begin
			AWADDR_I <= {idx, 2'h0};
			WDATA_I <= {24'h0, d};
			WSTRB_I <= strb;
			AWVALID_I <= 1'h1;
			WVALID_I <= 1'h1;
		end
		else
		begin
			ARADDR_I <= {idx, 2'h0};
			ARVALID_I <= 1'h1;
		end
		pa = w;
		pw = w;
		pr = !w;
		fin = 1'h0;
		for (int n = 0; n < 50 && !fin; n++)
		begin
			@(negedge REF_CLK_I);
			ta = pa && AWREADY_O;
			tw = pw && WREADY_O;
			tr = pr && ARREADY_O;
			tb = w ? BVALID_O : RVALID_O;
			rr = w ? BREADY_I : RREADY_I;
			q = RDATA_O;
			r = w ? BRESP_O : RRESP_O;
			@(posedge REF_CLK_I);
			if (ta)
			begin
				AWVALID_I <= 1'h0;
				pa = 1'h0;
			end
			if (tw)
			begin
				WVALID_I <= 1'h0;
				pw = 1'h0;
			end
			if (tr)
			begin
				ARVALID_I <= 1'h0;
				pr = 1'h0;
			end
			// Ready follows valid by a cycle so the hold checks see a wait
			if (tb && rr)
			begin
				BREADY_I <= 1'h0;
				RREADY_I <= 1'h0;
				fin = 1'h1;
			end
			else if (tb)
			begin
				BREADY_I <= w;
				RREADY_I <= !w;
			end
		end
		give_up(!fin);
	endtask : bus

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge REF_CLK_I);
		RSTN_I <= 1'h1;
		bus(0, IDX_REMOTE_MUX, 8'h0);
		chk(q, 32'h0);
		chk(32'(REMOTE_MUX_SEL_O), 32'h0);
		bus(0, IDX_ONESHOT, 8'h0);
		chk(q, 32'h0);
		foreach (rows[i])
		begin
			bus(1, rows[i].idx, rows[i].wd);
			chk(32'(r), 32'(rows[i].rsp));
			bus(0, rows[i].idx, 8'h0);
			chk(q, rows[i].rd);
			chk(32'(r), 32'(rows[i].rsp));
		end
		chk(32'({TEST_MUX_SEL_O, TEST_MUX_TWO_SEL_O, REMOTE_MUX_SEL_O}),
			32'({6'h2a, 5'h1f, 3'h5}));
		// Write with lane 0 off leaves the select alone
		strb = 4'he;
		bus(1, IDX_TEST_MUX, 8'h11);
		strb = 4'hf;
		chk(32'(TEST_MUX_SEL_O), 32'h2a);
		bus(1, IDX_TEMP_CTRL, 8'hd0);
		bus(0, IDX_TEMP_CTRL, 8'h0);
		chk(q, 32'hd8);
		bus(1, IDX_TEMP_CTRL, 8'h00);
		repeat (30) @(posedge REF_CLK_I);
		bus(0, IDX_TEMP_CTRL, 8'h0);
		chk(q, 32'hd0);
		chk(32'({MEAS_BAT_EN_O, MEAS_BAT_SEL_O, SENSOR_SUPPLY_MAIN_O}), 32'h7);
		MODE_I <= MODE_SLEEP;
		s0 = st_cnt;
		bus(1, IDX_ONESHOT, 8'h40);
		repeat (20) @(posedge REF_CLK_I);
		chk(32'(SENSOR_SUPPLY_MAIN_O), 32'h0);
		chk(st_cnt - s0, 32'h0);
		MODE_I <= MODE_MISSION;
		bus(1, IDX_ONESHOT, 8'h40);
		bus(0, IDX_ONESHOT, 8'h0);
		chk(q, 32'h40);
		for (k = 0; k < 20 && q[6]; k++)
			bus(0, IDX_ONESHOT, 8'h0);
		give_up(q[6]);
		chk(q, 32'h0);
		chk(st_cnt - s0, 32'h1);
		bus(0, IDX_RESULT_LO, 8'h0);
		chk(q, 32'h3c);
		bus(0, IDX_RESULT_HI, 8'h0);
		chk(q, 32'h5a);
		MODE_I <= MODE_SLEEP;
		lat <= 8'h2;
		s0 = st_cnt;
		bus(1, IDX_TEMP_CTRL, 8'h07);
		repeat (60) @(posedge REF_CLK_I);
		chk(32'(st_cnt - s0 > 4), 32'h1);
		MODE_I <= MODE_BROWNOUT;
		lat <= 8'h1e;
		tick_en <= 1'h1;
		bus(0, IDX_MODE, 8'h0);
		chk(q, 32'(MODE_BROWNOUT));
		for (int n = 1; n < 7; n++)
		begin
			repeat (30) @(posedge REF_CLK_I);
			bus(1, IDX_TEMP_CTRL, n[7:0]);
			s0 = st_cnt;
			for (k = 0; k < 7000 && st_cnt < s0 + 3; k++)
				@(posedge REF_CLK_I);
			give_up(st_cnt < s0 + 3);
			chk(gap, 4 << (3 + n));
		end
		// Reset in mid-run returns the selects and the period to zero
		RSTN_I <= 1'h0;
		repeat (2) @(posedge REF_CLK_I);
		RSTN_I <= 1'h1;
		chk(32'({TEST_MUX_SEL_O, REMOTE_MUX_SEL_O, MEAS_START_O}), 32'h0);
		bus(0, IDX_TEMP_CTRL, 8'h0);
		chk(q, 32'h0);
		tally_and_finish;
	end
endmodule : temperature_measure_control_tb
`default_nettype wire
